//--- rtl/tqsel_top.sv
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "tqsel_cfg.svh"

// Functional notes
// - each select contact reads 0 when open and 1 when closed.
// - both selects 0 with the zero-torque variant gives a command of exactly zero.
// - both selects 0 with the analog variant takes the analog reference (-10 V to +10 V).
// - a nonzero select picks preset one (01), two (10) or three (11), each -300 % to 300 %.
// - a new preset becomes the command as soon as a select line changes.
// - in position and speed modes the selected source is a torque limit, not a command.
// - the source follows the two selects together with the analog-versus-zero variant.
// - in torque mode the analog command is smoothed, 0 to 1000 ms, 0 meaning bypass.
// - percent torque is input volts times the full-scale setting divided by 10.
// - full scale is held in percent, 0 to 1000, default 100.
// - selects are honoured only once the servo is enabled.
// - mode codes 06, 07, 08 are pulse/speed, pulse/torque, table/speed dual modes.
// - mode codes 09, 0A, 0D are table/torque, speed/torque, pulse/table dual modes.
// - zero-speed and zero-torque variants never appear inside a dual mode.

module tqsel_top #(
    parameter int W = 16,
    parameter int SMOOTH_TICK_CYCLES = `TQ_SMOOTH_UNIT_NS / `TQ_CLK_PERIOD_NS,
    parameter logic [W-1:0] ANALOG_FULL_CODE = `TQ_ANALOG_FULL_CODE
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic torque_select_bit0,
    input wire logic torque_select_bit1,
    input wire logic servo_enable,
    input wire logic mode_switch,
    input wire logic signed [W-1:0] analog_ref_code,
    output logic signed [W-1:0] torque_cmd,
    output logic signed [W-1:0] torque_limit,
    output logic limit_active,
    output logic [2:0] active_mode,
    output logic dual_mode
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic signed [W-1:0] sat_pct(input logic signed [W+1:0] v);
        logic signed [W+1:0] lim;
        lim = $signed({2'b00, `TQ_PCT_MAX});
        if (v > lim) begin
            sat_pct = W'(lim);
        end else if (v < -lim) begin
            sat_pct = W'(-lim);
        end else begin
            sat_pct = W'(v);
        end
    endfunction

    function automatic logic [W-1:0] cap_u(input logic [W-1:0] v, input logic [W-1:0] mx);
        cap_u = (v > mx) ? mx : v;
    endfunction

    // ----------------------------------------------------------------
    // registers and bus pipeline
    // ----------------------------------------------------------------
    logic [W-1:0] mode_reg;
    logic [W-1:0] smooth_reg;
    logic [W-1:0] fullscale_reg;
    logic signed [W-1:0] preset1_reg;
    logic signed [W-1:0] preset2_reg;
    logic signed [W-1:0] preset3_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [15:0] idx_reg;
    logic addr_ok_reg;
    logic take;
    logic sel0_meta_reg, sel0_reg, sel1_meta_reg, sel1_reg;
    logic en_meta_reg, en_reg, sw_meta_reg, sw_reg;
    logic [31:0] rd_word;

    assign take = hsel && htrans[1] && hready;

    // reads wait one cycle so a write just ahead is already stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            idx_reg <= 16'h0000;
            addr_ok_reg <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            if (rd_pend_reg) begin
                rd_pend_reg <= 1'b0;
                hreadyout <= 1'b1;
            end else begin
                wr_pend_reg <= take && hwrite;
                rd_pend_reg <= take && !hwrite;
                hreadyout <= !(take && !hwrite);
            end
            if (take) begin
                idx_reg <= haddr[17:2];
                addr_ok_reg <= (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= `TQ_RST_MODE;
            smooth_reg <= `TQ_RST_SMOOTH;
            fullscale_reg <= `TQ_RST_FULLSCALE;
            preset1_reg <= `TQ_RST_PRESET;
            preset2_reg <= `TQ_RST_PRESET;
            preset3_reg <= `TQ_RST_PRESET;
        end else if (wr_pend_reg && addr_ok_reg) begin
            case (idx_reg)
                `TQ_IDX_MODE: begin
                    mode_reg <= hwdata[W-1:0];
                end
                `TQ_IDX_SMOOTH: begin
                    smooth_reg <= cap_u(hwdata[W-1:0], `TQ_MAX_SMOOTH);
                end
                // full scale 0 to 1000 %
                `TQ_IDX_FULLSCALE: begin
                    fullscale_reg <= cap_u(hwdata[W-1:0], `TQ_MAX_FULLSCALE);
                end
                // presets held within -300 to 300 %
                `TQ_IDX_PRESET1: begin
                    preset1_reg <= sat_pct({{2{hwdata[W-1]}}, hwdata[W-1:0]});
                end
                `TQ_IDX_PRESET2: begin
                    preset2_reg <= sat_pct({{2{hwdata[W-1]}}, hwdata[W-1:0]});
                end
                `TQ_IDX_PRESET3: begin
                    preset3_reg <= sat_pct({{2{hwdata[W-1]}}, hwdata[W-1:0]});
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // closed contact reads as 1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel0_meta_reg <= 1'b0;
            sel0_reg <= 1'b0;
            sel1_meta_reg <= 1'b0;
            sel1_reg <= 1'b0;
            en_meta_reg <= 1'b0;
            en_reg <= 1'b0;
            sw_meta_reg <= 1'b0;
            sw_reg <= 1'b0;
        end else begin
            sel0_meta_reg <= torque_select_bit0;
            sel0_reg <= sel0_meta_reg;
            sel1_meta_reg <= torque_select_bit1;
            sel1_reg <= sel1_meta_reg;
            en_meta_reg <= servo_enable;
            en_reg <= en_meta_reg;
            sw_meta_reg <= mode_switch;
            sw_reg <= sw_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // control mode decode
    // ----------------------------------------------------------------
    tqsel_pkg::tqsel_mode_t mode_now;
    logic dual_now;
    logic [7:0] code;

    assign code = mode_reg[`TQ_MODE_CODE_MSB:0];

    // switch on picks the torque or speed member; table wins in pulse/table
    always_comb begin
        dual_now = 1'b1;
        case (code)
            `TQ_CODE_PT: begin
                mode_now = tqsel_pkg::TQSEL_MODE_PT;
                dual_now = 1'b0;
            end
            `TQ_CODE_PR: begin
                mode_now = tqsel_pkg::TQSEL_MODE_PR;
                dual_now = 1'b0;
            end
            `TQ_CODE_S: begin
                mode_now = tqsel_pkg::TQSEL_MODE_S;
                dual_now = 1'b0;
            end
            `TQ_CODE_T: begin
                mode_now = tqsel_pkg::TQSEL_MODE_T;
                dual_now = 1'b0;
            end
            `TQ_CODE_SZ: begin
                mode_now = tqsel_pkg::TQSEL_MODE_SZ;
                dual_now = 1'b0;
            end
            `TQ_CODE_TZ: begin
                mode_now = tqsel_pkg::TQSEL_MODE_TZ;
                dual_now = 1'b0;
            end
            // pulse or table against speed, pulse against torque
            `TQ_CODE_PT_S: begin
                mode_now = sw_reg ? tqsel_pkg::TQSEL_MODE_S : tqsel_pkg::TQSEL_MODE_PT;
            end
            `TQ_CODE_PT_T: begin
                mode_now = sw_reg ? tqsel_pkg::TQSEL_MODE_T : tqsel_pkg::TQSEL_MODE_PT;
            end
            `TQ_CODE_PR_S: begin
                mode_now = sw_reg ? tqsel_pkg::TQSEL_MODE_S : tqsel_pkg::TQSEL_MODE_PR;
            end
            // dual members are never the zero variants
            `TQ_CODE_PR_T: begin
                mode_now = sw_reg ? tqsel_pkg::TQSEL_MODE_T : tqsel_pkg::TQSEL_MODE_PR;
            end
            `TQ_CODE_S_T: begin
                mode_now = sw_reg ? tqsel_pkg::TQSEL_MODE_T : tqsel_pkg::TQSEL_MODE_S;
            end
            `TQ_CODE_PT_PR: begin
                mode_now = sw_reg ? tqsel_pkg::TQSEL_MODE_PR : tqsel_pkg::TQSEL_MODE_PT;
            end
            default: begin
                mode_now = tqsel_pkg::TQSEL_MODE_NONE;
                dual_now = 1'b0;
            end
        endcase
    end

    logic torque_mode;
    logic zero_variant;

    assign torque_mode = (mode_now == tqsel_pkg::TQSEL_MODE_T)
        || (mode_now == tqsel_pkg::TQSEL_MODE_TZ);
    // the zero bit only counts in a single mode
    assign zero_variant = (mode_now == tqsel_pkg::TQSEL_MODE_TZ)
        || (!dual_now && mode_reg[`TQ_MODE_ZERO_BIT]);

    // ----------------------------------------------------------------
    // analog scaling and smoothing
    // ----------------------------------------------------------------
    logic signed [2*W+1:0] prod;
    logic signed [2*W+1:0] quot;
    logic signed [W-1:0] analog_pct_reg;
    logic signed [W-1:0] analog_sm;

    // code over full code stands for volts over 10
    assign prod = analog_ref_code * $signed({2'b00, fullscale_reg});
    assign quot = prod / $signed({{(W+2){1'b0}}, ANALOG_FULL_CODE});

    // clamp before smoothing keeps the filter in range
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_pct_reg <= '0;
        end else if (quot > $signed({{(W+2){1'b0}}, `TQ_PCT_MAX})) begin
            analog_pct_reg <= $signed(`TQ_PCT_MAX);
        end else if (quot < -$signed({{(W+2){1'b0}}, `TQ_PCT_MAX})) begin
            analog_pct_reg <= -$signed(`TQ_PCT_MAX);
        end else begin
            analog_pct_reg <= W'(quot);
        end
    end

    // smoothing only while in torque mode
    tqsel_smooth #(
        .W(W),
        .TC_W(W),
        .TICK_CYCLES(SMOOTH_TICK_CYCLES)
    ) u_smooth (
        .hclk(hclk),
        .hresetn(hresetn),
        .bypass(!torque_mode),
        .tc(smooth_reg),
        .x(analog_pct_reg),
        .y(analog_sm)
    );

    // ----------------------------------------------------------------
    // source selection
    // ----------------------------------------------------------------
    tqsel_pkg::tqsel_src_t src;
    logic signed [W-1:0] sel_val;

    // selects plus variant choose the source
    // before servo enable the selects are read as 00
    always_comb begin
        case ({en_reg & sel1_reg, en_reg & sel0_reg})
            // applied on the select change itself
            2'b01: begin
                src = tqsel_pkg::TQSEL_SRC_PRESET1;
                sel_val = preset1_reg;
            end
            2'b10: begin
                src = tqsel_pkg::TQSEL_SRC_PRESET2;
                sel_val = preset2_reg;
            end
            2'b11: begin
                src = tqsel_pkg::TQSEL_SRC_PRESET3;
                sel_val = preset3_reg;
            end
            default: begin
                src = zero_variant ? tqsel_pkg::TQSEL_SRC_ZERO : tqsel_pkg::TQSEL_SRC_ANALOG;
                sel_val = zero_variant ? '0 : analog_sm;
            end
        endcase
    end

    tqsel_pkg::tqsel_src_t src_reg;

    // torque mode gives a command, position and speed a limit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            torque_cmd <= '0;
            torque_limit <= '0;
            limit_active <= 1'b0;
            active_mode <= 3'(tqsel_pkg::TQSEL_MODE_NONE);
            dual_mode <= 1'b0;
            src_reg <= tqsel_pkg::TQSEL_SRC_ZERO;
        end else begin
            torque_cmd <= torque_mode ? sel_val : '0;
            torque_limit <= (torque_mode || mode_now == tqsel_pkg::TQSEL_MODE_NONE) ? '0 : sel_val;
            limit_active <= !torque_mode && (mode_now != tqsel_pkg::TQSEL_MODE_NONE);
            active_mode <= 3'(mode_now);
            dual_mode <= dual_now;
            src_reg <= src;
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        if (addr_ok_reg) begin
            case (idx_reg)
                `TQ_IDX_MODE: rd_word = {16'h0000, mode_reg};
                `TQ_IDX_SMOOTH: rd_word = {16'h0000, smooth_reg};
                `TQ_IDX_FULLSCALE: rd_word = {16'h0000, fullscale_reg};
                `TQ_IDX_PRESET1: rd_word = {{16{preset1_reg[W-1]}}, preset1_reg};
                `TQ_IDX_PRESET2: rd_word = {{16{preset2_reg[W-1]}}, preset2_reg};
                `TQ_IDX_PRESET3: rd_word = {{16{preset3_reg[W-1]}}, preset3_reg};
                `TQ_IDX_STATUS: rd_word = {20'h0_0000, en_reg, sel1_reg, sel0_reg,
                    limit_active, dual_mode, active_mode, 1'b0, 3'(src_reg)};
                `TQ_IDX_CMD: rd_word = {torque_limit, torque_cmd};
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            hrdata <= rd_word;
        end
    end

endmodule

//--- common/tqsel_cfg.svh
`ifndef TQSEL_CFG_SVH
`define TQSEL_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TQ_IDX_MODE 16'h0101
`define TQ_IDX_SMOOTH 16'h010e
`define TQ_IDX_PRESET1 16'h0118
`define TQ_IDX_PRESET2 16'h011a
`define TQ_IDX_PRESET3 16'h011c
`define TQ_IDX_FULLSCALE 16'h0152
`define TQ_IDX_STATUS 16'h0180
`define TQ_IDX_CMD 16'h0182

// ----------------------------------------------------------------
// reset values and ranges
// ----------------------------------------------------------------
`define TQ_RST_SMOOTH 16'h0000
`define TQ_RST_FULLSCALE 16'h0064
`define TQ_RST_PRESET 16'h0000
`define TQ_RST_MODE 16'h0003
`define TQ_MAX_SMOOTH 16'h03e8
`define TQ_MAX_FULLSCALE 16'h03e8
`define TQ_PCT_MAX 16'h012c
`define TQ_ANALOG_FULL_CODE 16'h7fff

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define TQ_MODE_CODE_MSB 7
`define TQ_MODE_ZERO_BIT 8

// ----------------------------------------------------------------
// control mode codes
// ----------------------------------------------------------------
`define TQ_CODE_PT 8'h00
`define TQ_CODE_PR 8'h01
`define TQ_CODE_S 8'h02
`define TQ_CODE_T 8'h03
`define TQ_CODE_SZ 8'h04
`define TQ_CODE_TZ 8'h05
`define TQ_CODE_PT_S 8'h06
`define TQ_CODE_PT_T 8'h07
`define TQ_CODE_PR_S 8'h08
`define TQ_CODE_PR_T 8'h09
`define TQ_CODE_S_T 8'h0a
`define TQ_CODE_PT_PR 8'h0d

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TQ_CLK_PERIOD_NS 5
`define TQ_SMOOTH_UNIT_NS 1000000

`endif

//--- common/tqsel_pkg.sv
package tqsel_pkg;

    typedef enum logic [2:0] {
        TQSEL_SRC_ZERO,
        TQSEL_SRC_ANALOG,
        TQSEL_SRC_PRESET1,
        TQSEL_SRC_PRESET2,
        TQSEL_SRC_PRESET3
    } tqsel_src_t;

    typedef enum logic [2:0] {
        TQSEL_MODE_PT,
        TQSEL_MODE_PR,
        TQSEL_MODE_S,
        TQSEL_MODE_T,
        TQSEL_MODE_SZ,
        TQSEL_MODE_TZ,
        TQSEL_MODE_NONE
    } tqsel_mode_t;

endpackage

//--- rtl/tqsel_smooth.sv
`timescale 1ns/1ps
`include "tqsel_cfg.svh"

module tqsel_smooth #(
    parameter int W = 16,
    parameter int TC_W = 16,
    parameter int TICK_CYCLES = 200000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic bypass,
    input wire logic [TC_W-1:0] tc,
    input wire logic signed [W-1:0] x,
    output logic signed [W-1:0] y
);
    // eight fraction bits so that small steps still move the output
    localparam int FW = W + 8;

    logic [31:0] tick_cnt_reg;
    logic tick;
    logic signed [FW-1:0] acc_reg;
    logic signed [FW:0] diff;
    logic signed [FW:0] step;

    assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
    assign diff = {x[W-1], x, 8'h00} - {acc_reg[FW-1], acc_reg};
    assign step = diff / $signed({1'b0, {(FW-TC_W){1'b0}}, tc});

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else if (tick) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
        end
    end

    // first-order lag, zero setting passes through
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_reg <= '0;
        end else if (bypass || (tc == '0)) begin
            acc_reg <= {x, 8'h00};
        end else if (tick) begin
            acc_reg <= FW'(acc_reg + step);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            y <= '0;
        end else begin
            y <= acc_reg[FW-1:8];
        end
    end

endmodule

//--- tb/tqsel_ctl_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// external controller: select contacts, enable, analog reference
// ------------------------------------------
module tqsel_ctl_model (
    input wire logic hclk,
    output logic torque_select_bit0,
    output logic torque_select_bit1,
    output logic servo_enable,
    output logic mode_switch,
    output logic signed [15:0] analog_ref_code
);
    initial begin
        torque_select_bit0 = 1'b0;
        torque_select_bit1 = 1'b0;
        servo_enable = 1'b0;
        mode_switch = 1'b0;
        analog_ref_code = 16'sh0000;
    end
    // contacts and enable on the same edge
    // a closed contact drives 1; the bench decides when enable leads the selects
    task automatic drive(input logic [1:0] s, input logic en, input logic sw,
                         input logic signed [15:0] a);
        @(posedge hclk);
        torque_select_bit0 <= s[0];
        torque_select_bit1 <= s[1];
        servo_enable <= en;
        mode_switch <= sw;
        analog_ref_code <= a;
    endtask
endmodule

//--- tb/tqsel_top_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------
// port checker
// ------------------------------------------
module tqsel_top_asserts #(
    parameter int W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic signed [W-1:0] torque_cmd,
    input wire logic signed [W-1:0] torque_limit,
    input wire logic limit_active,
    input wire logic [2:0] active_mode,
    input wire logic dual_mode
);
    logic take;
    assign take = hsel && htrans[1] && hready;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
    a_write_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_limit_no_cmd: assert property (limit_active [*4] |-> torque_cmd == 0)
        else $error("command nonzero while limiting");
    a_torque_no_limit: assert property (!limit_active [*4] |-> torque_limit == 0)
        else $error("limit nonzero in torque mode");
    a_limit_pos_speed: assert property (limit_active |-> active_mode inside
        {tqsel_pkg::TQSEL_MODE_PT, tqsel_pkg::TQSEL_MODE_PR, tqsel_pkg::TQSEL_MODE_S,
        tqsel_pkg::TQSEL_MODE_SZ}) else $error("limit in wrong mode");
    a_cmd_saturated: assert property (torque_cmd <= $signed(16'h012c) &&
        torque_cmd >= -$signed(16'h012c)) else $error("command out of range");
    a_limit_saturated: assert property (torque_limit <= $signed(16'h012c) &&
        torque_limit >= -$signed(16'h012c)) else $error("limit out of range");
    a_dual_no_zero: assert property (dual_mode |-> !(active_mode inside
        {tqsel_pkg::TQSEL_MODE_SZ, tqsel_pkg::TQSEL_MODE_TZ})) else $error("zero mode in pair");
    a_none_silent: assert property ((active_mode == tqsel_pkg::TQSEL_MODE_NONE) [*4]
        |-> torque_cmd == 0 && torque_limit == 0 && !dual_mode) else $error("bad code not idle");
endmodule
bind tqsel_top tqsel_top_asserts #(.W(W)) i_asserts (.hclk, .hresetn, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .torque_cmd, .torque_limit, .limit_active,
    .active_mode, .dual_mode);

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "tqsel_cfg.svh"
module testbench;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic torque_select_bit0, torque_select_bit1, servo_enable, mode_switch, limit_active;
    logic signed [15:0] analog_ref_code, torque_cmd, torque_limit;
    logic [2:0] active_mode;
    logic dual_mode;
    logic [31:0] rd;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic signed [15:0] pre [3] = '{16'sh0096, 16'shff38, 16'sh012c};
    logic [15:0] codes [12] = '{16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h000a, 16'h000d,
                               16'h0106, 16'h000b, 16'h0001, 16'h0002, 16'h0004, 16'h0005};
    logic [2:0] m0 [12] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h0, 3'h0, 3'h6, 3'h1, 3'h2, 3'h4,
                            3'h5};
    logic [2:0] m1 [12] = '{3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h1, 3'h2, 3'h6, 3'h1, 3'h2, 3'h4,
                            3'h5};
    // ------------------------------------------
    // design, controller and clock
    // ------------------------------------------
    // smoothing tick shortened to 4 cycles so the filter settles within the run
    tqsel_top #(.SMOOTH_TICK_CYCLES(4)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .torque_select_bit0, .torque_select_bit1, .servo_enable, .mode_switch,
        .analog_ref_code, .torque_cmd, .torque_limit, .limit_active, .active_mode, .dual_mode);
    tqsel_ctl_model i_ctl (.hclk, .torque_select_bit0, .torque_select_bit1, .servo_enable,
        .mode_switch, .analog_ref_code);
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {14'h0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input logic [1:0] s, input logic en, input logic sw,
                        input logic signed [15:0] a);
        i_ctl.drive(s, en, sw, a);
        repeat (8) @(posedge hclk);
    endtask
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        finish_test;
    end
    // ------------------------------------------
    // tests
    // ------------------------------------------
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, `TQ_IDX_SMOOTH, 0);
        check("smooth reset", rd, 32'h0000_0000);
        bus(0, `TQ_IDX_FULLSCALE, 0);
        check("scale reset", rd, 32'h0000_0064);
        bus(0, 16'h0fff, 0);
        check("unmapped", rd, 32'h0000_0000);
        bus(1, `TQ_IDX_FULLSCALE, 32'h0000_07d0);
        bus(0, `TQ_IDX_FULLSCALE, 0);
        check("scale clamp", rd, 32'h0000_03e8);
        bus(1, `TQ_IDX_FULLSCALE, 32'h0000_0064);
        for (int i = 0; i < 3; i++) begin
            bus(1, `TQ_IDX_PRESET1 + 16'(2 * i), 32'(pre[i]));
            bus(0, `TQ_IDX_PRESET1 + 16'(2 * i), 0);
            check("preset", rd, 32'(pre[i]));
        end
        $display("test registers done");
        // selects change back to back; servo on first
        step(2'b00, 1, 0, 16'sh0000);
        check("servo on", torque_cmd, 16'sh0000);
        for (int i = 1; i < 4; i++) begin
            step(2'(i), 1, 0, 16'sh0000);
            check("preset cmd", torque_cmd, pre[i-1]);
        end
        bus(1, `TQ_IDX_CMD, 0);
        bus(0, `TQ_IDX_CMD, 0);
        check("cmd reg", rd[15:0], pre[2]);
        step(2'b00, 1, 0, 16'sh7fff);
        check("analog full", torque_cmd, 16'sh0064);
        bus(1, `TQ_IDX_FULLSCALE, 32'h0000_00c8);
        step(2'b00, 1, 0, 16'shc000);
        check("analog half", torque_cmd, 16'shff9c);
        bus(1, `TQ_IDX_FULLSCALE, 32'h0000_03e8);
        step(2'b00, 1, 0, 16'sh7fff);
        check("analog sat", torque_cmd, 16'sh012c);
        bus(1, `TQ_IDX_FULLSCALE, 32'h0000_0064);
        step(2'b11, 0, 0, 16'sh7fff);
        check("servo off", torque_cmd, 16'sh0064);
        bus(1, `TQ_IDX_MODE, 32'h0000_0103);
        step(2'b00, 1, 0, 16'sh7fff);
        check("zero variant", torque_cmd, 16'sh0000);
        $display("test torque sources done");
        bus(1, `TQ_IDX_MODE, 32'h0000_0000);
        step(2'b01, 1, 0, 16'sh0000);
        check("limit flag", limit_active, 1);
        check("limit", torque_limit, pre[0]);
        check("no cmd", torque_cmd, 16'sh0000);
        bus(0, `TQ_IDX_STATUS, 0);
        check("status", rd, 32'h0000_0b02);
        $display("test torque limit done");
        for (int i = 0; i < 12; i++) begin
            bus(1, `TQ_IDX_MODE, {16'h0000, codes[i]});
            for (int s = 0; s < 2; s++) begin
                step(2'b01, 1, s[0], 16'sh0000);
                check("mode", active_mode, s ? m1[i] : m0[i]);
                check("dual", dual_mode, i < 7);
                check("mode limit", limit_active,
                    !((s ? m1[i] : m0[i]) inside {3'h3, 3'h5, 3'h6}));
            end
        end
        $display("test dual modes done");
        bus(1, `TQ_IDX_MODE, 32'h0000_0003);
        step(2'b00, 1, 0, 16'sh0000);
        bus(1, `TQ_IDX_SMOOTH, 32'h0000_1000);
        bus(0, `TQ_IDX_SMOOTH, 0);
        check("smooth clamp", rd, 32'h0000_03e8);
        bus(1, `TQ_IDX_SMOOTH, 32'h0000_0002);
        step(2'b00, 1, 0, 16'sh7fff);
        check("smoothing", torque_cmd < 16'sh0064, 1);
        repeat (400) @(posedge hclk);
        check("smoothed", torque_cmd > 16'sh005f, 1);
        $display("test smoothing done");
        finish_test;
    end
endmodule
